// File: src/rtc_irq_pkg.sv
`default_nettype none
package rtc_irq_pkg;
   // ----------------------------------------
   // Register map, word index and byte address
   // ----------------------------------------
   localparam logic [3:0] IDX_CONTROL_ONE  = 4'h0;
   localparam logic [3:0] IDX_CONTROL_TWO  = 4'h1;
   localparam logic [3:0] IDX_TIMER_CTRL   = 4'hE;
   localparam logic [3:0] IDX_TIMER_VALUE  = 4'hF;
   localparam int         ADDR_W           = 6;
   localparam int         ADDR_LSB         = 2;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_EXT_TEST      = 7;
   localparam int BIT_HALT          = 5;
   localparam int BIT_POR_OVERRIDE  = 3;
   localparam int BIT_PULSE_MODE    = 4;
   localparam int BIT_ALARM_FLAG    = 3;
   localparam int BIT_COUNT_FLAG    = 2;
   localparam int BIT_ALARM_IE      = 1;
   localparam int BIT_COUNT_IE      = 0;
   localparam int BIT_TIMER_ENABLE  = 7;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic       RST_EXT_TEST     = 1'b0;
   localparam logic       RST_HALT         = 1'b0;
   localparam logic       RST_POR_OVERRIDE = 1'b1;
   localparam logic [1:0] RST_TIMER_SRC    = 2'h3;
   localparam logic [7:0] RST_COUNT_VALUE  = 8'h00;

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------
   // Divider chain, counted in crystal edges
   // ----------------------------------------
   localparam int         CRYSTAL_HZ   = 32768;
   localparam int         DIV_W        = 15;
   localparam logic [DIV_W-1:0] DIV_MASK_4096 = DIV_W'(CRYSTAL_HZ / 4096 - 1);
   localparam logic [DIV_W-1:0] DIV_MASK_64   = DIV_W'(CRYSTAL_HZ / 64 - 1);
   localparam logic [DIV_W-1:0] DIV_MASK_1    = DIV_W'(CRYSTAL_HZ - 1);
   localparam logic [5:0] SECONDS_PER_MIN_M1  = 6'h3B;

   typedef enum logic [1:0] {
      SRC_4096, SRC_64, SRC_1, SRC_SIXTIETH
   } timer_src_t;

   // ----------------------------------------
   // Pulse widths in crystal edges
   // ----------------------------------------
   localparam int PW_W = 10;
   localparam logic [PW_W-1:0] PW_4096_SHORT = PW_W'(CRYSTAL_HZ / 8192);
   localparam logic [PW_W-1:0] PW_4096_LONG  = PW_W'(CRYSTAL_HZ / 4096);
   localparam logic [PW_W-1:0] PW_64_SHORT   = PW_W'(CRYSTAL_HZ / 128);
   localparam logic [PW_W-1:0] PW_64_LONG    = PW_W'(CRYSTAL_HZ / 64);
   localparam logic [PW_W-1:0] PW_SLOW       = PW_W'(CRYSTAL_HZ / 64);
endpackage
`default_nettype wire

// File: src/rtc_control_and_interrupt.sv
// Notes on behaviour
// [R01] Control one bit 7 selects external clock test mode; resets to normal.
// [R02] Halt bit 5 clears the divider chain and stops the time base.
// [R03] Crystal rate square wave stays available while the time base is halted.
// [R04] Control one bit 3 enables power-on-reset override; resets to one.
// [R05] Host writes zero to every reserved bit of both control registers.
// [R06] Level mode: interrupt follows countdown flag, gated by its enable.
// [R07] Pulse mode: countdown event gives a gated pulse instead of a level.
// [R08] Alarm flag with alarm enable holds interrupt asserted, even in pulse mode.
// [R09] Alarm match sets alarm flag, control two bit 3.
// [R10] Countdown end sets countdown flag, control two bit 2.
// [R11] Both flags stay set until the host overwrites them.
// [R12] Control two write ANDs each flag with the written bit.
// [R13] Host reads both flags to tell which source interrupted.
// [R14] Bit 1 gates the alarm flag, bit 0 the countdown flag.
// [R15] Interrupt is the OR of both enabled conditions.
// [R16] Pulse width follows source clock and loaded value per table.
// [R17] In pulse mode flag and interrupt assert in the same cycle.
// [R18] Countdown timer does not run while its loaded value is zero.
// [R19] Interrupt output is open drain, asserted low.
// [R20] Countdown value and source select live in timer registers.
// [R21] An event in the same cycle as a clearing write keeps the flag set.
`default_nettype none
module rtc_control_and_interrupt
   import rtc_irq_pkg::*;
(
   input  wire  logic              core_clk,
   input  wire  logic              reset,
   input  wire  logic              clk_en,
   input  wire  logic [ADDR_W-1:0] awaddr,
   input  wire  logic              awvalid,
   output logic                    awready,
   input  wire  logic [31:0]       wdata,
   input  wire  logic [3:0]        wstrb,
   input  wire  logic              wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire  logic              bready,
   input  wire  logic [ADDR_W-1:0] araddr,
   input  wire  logic              arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire  logic              rready,
   input  wire  logic              crystal_pin,
   input  wire  logic              alarm_match,
   output logic                    square_wave_out,
   output logic                    irq_pin_out,
   output logic                    irq_pin_oe,
   output logic                    ext_clock_test_select,
   output logic                    por_override_enable,
   output logic                    divider_halted
);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic             halt;
   logic             countdown_irq_pulse_mode;
   logic             alarm_flag;
   logic             countdown_flag;
   logic             alarm_irq_enable;
   logic             countdown_irq_enable;
   logic             timer_enable;
   timer_src_t       timer_src;
   logic [7:0]       countdown_value;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic [ADDR_W-1:0] aw_addr;
   logic              aw_held;
   logic [7:0]        w_byte;
   logic              w_lane;
   logic              w_held;
   logic              wr_fire;
   logic [3:0]        wr_index;
   logic [3:0]        rd_index;
   logic              wr_mapped;
   logic              rd_mapped;
   logic [7:0]        next_rdata;

   assign awready  = !aw_held && !bvalid;
   assign wready   = !w_held && !bvalid;
   assign arready  = !rvalid;
   assign wr_fire  = clk_en && aw_held && w_held && !bvalid;
   assign wr_index = aw_addr[ADDR_LSB +: 4];
   assign rd_index = araddr[ADDR_LSB +: 4];
   assign wr_mapped = (wr_index == IDX_CONTROL_ONE) || (wr_index == IDX_CONTROL_TWO)
                   || (wr_index == IDX_TIMER_CTRL) || (wr_index == IDX_TIMER_VALUE);
   assign rd_mapped = (rd_index == IDX_CONTROL_ONE) || (rd_index == IDX_CONTROL_TWO)
                   || (rd_index == IDX_TIMER_CTRL) || (rd_index == IDX_TIMER_VALUE);

   // Address and data may arrive in either order
   always_ff @(posedge core_clk) begin
      if (reset) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_byte  <= 8'h00;
         w_lane  <= 1'b0;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Reserved bits read as zero, whatever the host wrote
   always_comb begin
      next_rdata = 8'h00;
      unique case (rd_index)
         IDX_CONTROL_ONE: begin
            next_rdata[BIT_EXT_TEST]     = ext_clock_test_select;
            next_rdata[BIT_HALT]         = halt;
            next_rdata[BIT_POR_OVERRIDE] = por_override_enable;
         end
         IDX_CONTROL_TWO: begin
            next_rdata[BIT_PULSE_MODE] = countdown_irq_pulse_mode;
            next_rdata[BIT_ALARM_FLAG] = alarm_flag;
            next_rdata[BIT_COUNT_FLAG] = countdown_flag;
            next_rdata[BIT_ALARM_IE]   = alarm_irq_enable;
            next_rdata[BIT_COUNT_IE]   = countdown_irq_enable;
         end
         IDX_TIMER_CTRL: begin
            next_rdata[BIT_TIMER_ENABLE] = timer_enable;
            next_rdata[1:0]              = timer_src;
         end
         IDX_TIMER_VALUE: next_rdata = countdown_value;
         default:         next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, next_rdata};
            rresp  <= rd_mapped ? RESP_OKAY : RESP_DECERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic wr_one;
   logic wr_two;
   logic wr_tctrl;
   logic wr_tvalue;

   assign wr_one    = wr_fire && w_lane && (wr_index == IDX_CONTROL_ONE);
   assign wr_two    = wr_fire && w_lane && (wr_index == IDX_CONTROL_TWO);
   assign wr_tctrl  = wr_fire && w_lane && (wr_index == IDX_TIMER_CTRL);
   assign wr_tvalue = wr_fire && w_lane && (wr_index == IDX_TIMER_VALUE);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ext_clock_test_select <= RST_EXT_TEST;                   // [R01]
         halt                  <= RST_HALT;
         por_override_enable   <= RST_POR_OVERRIDE;               // [R04]
      end else if (wr_one) begin
         ext_clock_test_select <= w_byte[BIT_EXT_TEST];           // [R01]
         halt                  <= w_byte[BIT_HALT];               // [R02]
         por_override_enable   <= w_byte[BIT_POR_OVERRIDE];       // [R04]
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         countdown_irq_pulse_mode <= 1'b0;
         alarm_irq_enable         <= 1'b0;
         countdown_irq_enable     <= 1'b0;
      end else if (wr_two) begin
         countdown_irq_pulse_mode <= w_byte[BIT_PULSE_MODE];
         alarm_irq_enable         <= w_byte[BIT_ALARM_IE];        // [R14]
         countdown_irq_enable     <= w_byte[BIT_COUNT_IE];        // [R14]
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         timer_enable    <= 1'b0;
         timer_src       <= timer_src_t'(RST_TIMER_SRC);
         countdown_value <= RST_COUNT_VALUE;
      end else begin
         if (wr_tctrl) begin
            timer_enable <= w_byte[BIT_TIMER_ENABLE];             // [R20]
            timer_src    <= timer_src_t'(w_byte[1:0]);            // [R20]
         end
         if (wr_tvalue) begin
            countdown_value <= w_byte;                            // [R20]
         end
      end
   end

   // ----------------------------------------
   // Crystal input and divider chain
   // ----------------------------------------
   logic             xtal_s1;
   logic             xtal_s2;
   logic             xtal_s3;
   logic             xtal_edge;
   logic [DIV_W-1:0] div_count;
   logic [5:0]       sec_count;
   logic             src_tick;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         xtal_s1 <= 1'b0;
         xtal_s2 <= 1'b0;
         xtal_s3 <= 1'b0;
      end else if (clk_en) begin
         xtal_s1 <= crystal_pin;
         xtal_s2 <= xtal_s1;
         xtal_s3 <= xtal_s2;
      end
   end
   assign xtal_edge = clk_en && xtal_s2 && !xtal_s3;

   // Square wave bypasses the divider, so halting never silences it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         square_wave_out <= 1'b0;
      end else if (clk_en) begin
         square_wave_out <= xtal_s2;                              // [R03]
      end
   end

   // Held at zero for the whole halt, not just once
   always_ff @(posedge core_clk) begin
      if (reset || (halt && clk_en)) begin
         div_count <= '0;                                         // [R02]
         sec_count <= 6'h00;
      end else if (xtal_edge) begin
         div_count <= div_count + DIV_W'(1);
         if (div_count == DIV_MASK_1) begin
            sec_count <= (sec_count == SECONDS_PER_MIN_M1) ? 6'h00 : sec_count + 6'h01;
         end
      end
   end
   assign divider_halted = halt;

   always_comb begin
      unique case (timer_src)
         SRC_4096:     src_tick = (div_count & DIV_MASK_4096) == DIV_MASK_4096;
         SRC_64:       src_tick = (div_count & DIV_MASK_64) == DIV_MASK_64;
         SRC_1:        src_tick = div_count == DIV_MASK_1;
         SRC_SIXTIETH: src_tick = div_count == DIV_MASK_1 && sec_count == SECONDS_PER_MIN_M1;
      endcase
   end

   // ----------------------------------------
   // Countdown timer
   // ----------------------------------------
   logic [7:0] timer_count;
   logic       countdown_event;
   logic       timer_runs;

   assign timer_runs      = timer_enable && !halt && (countdown_value != 8'h00); // [R18]
   assign countdown_event = timer_runs && xtal_edge && src_tick && timer_count <= 8'h01;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         timer_count <= RST_COUNT_VALUE;
      end else if (wr_tvalue) begin
         timer_count <= w_byte;
      end else if (timer_runs && xtal_edge && src_tick) begin
         timer_count <= (timer_count <= 8'h01) ? countdown_value : timer_count - 8'h01;
      end
   end

   // ----------------------------------------
   // Flags, set wins over a clearing write
   // ----------------------------------------
   logic alarm_set;

   assign alarm_set = clk_en && alarm_match;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         alarm_flag     <= 1'b0;
         countdown_flag <= 1'b0;
      end else begin
         if (alarm_set) begin
            alarm_flag <= 1'b1;                                   // [R09] [R21]
         end else if (wr_two) begin
            alarm_flag <= alarm_flag & w_byte[BIT_ALARM_FLAG];    // [R11] [R12]
         end
         if (countdown_event) begin
            countdown_flag <= 1'b1;                               // [R10] [R21]
         end else if (wr_two) begin
            countdown_flag <= countdown_flag & w_byte[BIT_COUNT_FLAG]; // [R11] [R12]
         end
      end
   end

   // ----------------------------------------
   // Pulse generator and interrupt pin
   // ----------------------------------------
   logic [PW_W-1:0] pulse_left;
   logic [PW_W-1:0] next_width;
   logic            pulse_active;
   logic            irq_active;

   always_comb begin
      unique case (timer_src)                                     // [R16]
         SRC_4096: next_width = (countdown_value == 8'h01) ? PW_4096_SHORT : PW_4096_LONG;
         SRC_64:   next_width = (countdown_value == 8'h01) ? PW_64_SHORT : PW_64_LONG;
         default:  next_width = PW_SLOW;
      endcase
   end

   // Width counted in crystal edges, so it tracks the source clock
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pulse_left <= '0;
      end else if (countdown_event) begin
         pulse_left <= next_width;                                // [R16] [R17]
      end else if (xtal_edge && pulse_left != '0) begin
         pulse_left <= pulse_left - PW_W'(1);
      end
   end
   assign pulse_active = pulse_left != '0;

   assign irq_active = (alarm_flag && alarm_irq_enable)                        // [R08] [R15]
                    || (countdown_irq_enable                                   // [R14]
                        && (countdown_irq_pulse_mode ? pulse_active            // [R07]
                                                     : countdown_flag));       // [R06]
   // Open drain: only ever pulls low
   assign irq_pin_out = 1'b0;                                     // [R19]
   assign irq_pin_oe  = irq_active;                               // [R19]

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_alarm_sets: assert property (alarm_set |=> alarm_flag)  // [R09]
      else $error("alarm match did not set alarm flag");
   a_count_sets: assert property (countdown_event |=> countdown_flag)  // [R10]
      else $error("countdown end did not set flag");
   a_flag_sticky: assert property (alarm_flag && !wr_two |=> alarm_flag)  // [R11]
      else $error("alarm flag dropped without a write");
   a_and_clear: assert property (wr_two && !w_byte[BIT_COUNT_FLAG] && !countdown_event
                                 |=> !countdown_flag)  // [R12]
      else $error("zero write did not clear countdown flag");
   a_set_beats_clear: assert property (wr_two && !w_byte[BIT_ALARM_FLAG] && alarm_set
                                       |=> alarm_flag)  // [R21]
      else $error("event lost under clearing write");
   a_alarm_holds: assert property (alarm_flag && alarm_irq_enable |-> irq_pin_oe)  // [R08]
      else $error("alarm interrupt not held");
   a_level_mode: assert property (!countdown_irq_pulse_mode && countdown_irq_enable
                                  |-> irq_pin_oe == (countdown_flag
                                  || (alarm_flag && alarm_irq_enable)))  // [R06]
      else $error("level mode does not follow flag");
   a_pulse_same: assert property (countdown_event && countdown_irq_pulse_mode
                                  && countdown_irq_enable |=> irq_pin_oe && countdown_flag) // [R17]
      else $error("pulse and flag not together");
   a_pulse_width: assert property (countdown_event && timer_src == SRC_4096
                                   && countdown_value == 8'h01
                                   |=> pulse_left == PW_4096_SHORT)  // [R16]
      else $error("short pulse width wrong");
   a_no_zero_run: assert property (countdown_value == 8'h00 |-> !countdown_event)  // [R18]
      else $error("timer ran with zero value");
   a_halt_clears: assert property (halt && clk_en |=> div_count == '0)  // [R02]
      else $error("divider not cleared while halted");
   a_square_runs: assert property (clk_en |=> square_wave_out == $past(xtal_s2))  // [R03]
      else $error("square wave stalled");
   a_por_default: assert property ($fell(reset) |-> por_override_enable
                                   && !ext_clock_test_select)  // [R04]
      else $error("control one reset values wrong");

   c_alarm_irq: cover property (alarm_set && alarm_irq_enable ##1 irq_pin_oe);
   c_pulse_irq: cover property (countdown_event && countdown_irq_pulse_mode ##1 irq_pin_oe);
   c_clear_race: cover property (wr_two && alarm_set);
   c_halted_run: cover property (halt && xtal_edge);
endmodule
`default_nettype wire

// File: sim/rtc_host_model.sv
`default_nettype none
module rtc_host_model (
   input  wire logic core_clk,
   input  wire logic irq_pin_out,
   input  wire logic irq_pin_oe,
   output var  logic crystal_pin,
   output wire logic irq_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Fast crystal, far above 32 kHz to keep runs short
   // ----------------------------------------
   logic phase;
   initial begin
      crystal_pin = 1'b0;
      phase = 1'b0;
   end
   always @(posedge core_clk) begin
      phase <= ~phase;
      if (phase) begin
         crystal_pin <= ~crystal_pin;
      end
   end
   // Pull-up wins when nobody drives the line
   assign irq_level = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h seen %h", nm, e, g); end end
module tb_top
   import rtc_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk, reset, clk_en, awvalid, wvalid, bready, arvalid, rready;
   logic              alarm_match, awready, wready, bvalid, arready, rvalid, sw;
   logic              square_wave_out, irq_pin_out, irq_pin_oe, crystal_pin, irq_level;
   logic              ext_clock_test_select, por_override_enable, divider_halted;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, seed;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   logic [33:0]       exp_q[$];
   int                mismatches, n_compared, n, i;
   rtc_control_and_interrupt rtc_control_and_interrupt_inst (.core_clk, .reset, .clk_en,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .crystal_pin,
      .alarm_match, .square_wave_out, .irq_pin_out, .irq_pin_oe, .ext_clock_test_select,
      .por_override_enable, .divider_halted);
   rtc_host_model rtc_host_model_inst (.core_clk, .irq_pin_out, .irq_pin_oe, .crystal_pin,
      .irq_level);
   always #5 core_clk = ~core_clk;
   // ----------------------------------------
   // Bus master tasks
   // ----------------------------------------
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
      int t;
      awaddr <= a;
      wdata <= {xorshift() & 32'hFFFFFF00} | {24'h0, d}; // Upper bits must be ignored
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (t = 0; t < 100; t++) begin
         @(posedge core_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [1:0] er, input logic [7:0] d);
      int t;
      exp_q.push_back({er, 24'h0, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (t = 0; t < 100; t++) begin
         @(posedge core_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rready <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wait_irq(input logic lvl);
      int t;
      for (t = 0; t < 2000 && irq_level !== lvl; t++) @(posedge core_clk);
      `CHK("irq_level", lvl, irq_level)
   endtask
   always @(posedge core_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK("read_queue", 1'b1, 1'b0)
         end else begin
            `CHK("read", exp_q.pop_front(), {rresp, rdata})
         end
      end
   end
   task automatic print_verdict();
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge core_clk);
      mismatches++;
      print_verdict();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {core_clk, clk_en, reset} = 3'b011;
      {awvalid, wvalid, bready, arvalid, rready, alarm_match} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {12'h000, 32'h0, 4'hF};
      {seed, mismatches, n_compared} = {32'h4A413DAF, 32'h0, 32'h0};
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(6'h00, RESP_OKAY, 8'h08);
      rd(6'h04, RESP_OKAY, 8'h00);
      rd(6'h3C, RESP_OKAY, 8'h00);
      rd(6'h08, RESP_DECERR, 8'h00);
      wr(6'h08, 8'h55, RESP_DECERR);
      wr(6'h00, 8'hA8, RESP_OKAY);
      rd(6'h00, RESP_OKAY, 8'hA8);
      `CHK("test_sel", 1'b1, ext_clock_test_select)
      `CHK("halted", 1'b1, divider_halted)
      sw = square_wave_out;
      repeat (2) @(posedge core_clk);
      `CHK("square_wave", ~sw, square_wave_out)
      // Clock enable low must freeze even the square wave path
      clk_en <= 1'b0;
      @(posedge core_clk);
      sw = square_wave_out;
      repeat (4) @(posedge core_clk);
      `CHK("frozen", sw, square_wave_out)
      clk_en <= 1'b1;
      @(posedge core_clk);
      wr(6'h00, 8'h00, RESP_OKAY);
      `CHK("halted", 1'b0, divider_halted)
      `CHK("por_override", 1'b0, por_override_enable)
      wr(6'h04, 8'h10, RESP_OKAY);
      alarm_match <= 1'b1;
      @(posedge core_clk);
      alarm_match <= 1'b0;
      repeat (8) @(posedge core_clk);
      `CHK("irq_masked", 1'b1, irq_level)
      wr(6'h04, 8'h1A, RESP_OKAY);
      repeat (40) @(posedge core_clk);
      `CHK("irq_alarm", 1'b0, irq_level)
      rd(6'h04, RESP_OKAY, 8'h1A);
      alarm_match <= 1'b1;
      wr(6'h04, 8'h12, RESP_OKAY);
      alarm_match <= 1'b0;
      rd(6'h04, RESP_OKAY, 8'h1A);
      wr(6'h04, 8'h12, RESP_OKAY);
      rd(6'h04, RESP_OKAY, 8'h12);
      `CHK("irq_clear", 1'b1, irq_level)
      wr(6'h3C, 8'h02, RESP_OKAY);
      wr(6'h38, 8'h80, RESP_OKAY);
      wr(6'h04, 8'h01, RESP_OKAY);
      wait_irq(1'b0);
      rd(6'h04, RESP_OKAY, 8'h05);
      wr(6'h38, 8'h00, RESP_OKAY);
      wr(6'h04, 8'h07, RESP_OKAY);
      `CHK("irq_or", 1'b0, irq_level)
      wr(6'h04, 8'h03, RESP_OKAY);
      `CHK("irq_none", 1'b1, irq_level)
      wr(6'h3C, 8'h00, RESP_OKAY);
      wr(6'h38, 8'h80, RESP_OKAY);
      repeat (300) @(posedge core_clk);
      rd(6'h04, RESP_OKAY, 8'h03);
      // Pulse widths at 4096 Hz, in core cycles, crystal edge every 4 cycles
      wr(6'h04, 8'h11, RESP_OKAY);
      for (i = 1; i < 3; i++) begin
         wr(6'h3C, 8'(i), RESP_OKAY);
         wait_irq(1'b1);
         wait_irq(1'b0);
         for (n = 0; n < 100 && irq_level === 1'b0; n++) @(posedge core_clk);
         `CHK("pulse_width", 1'b1, n >= 16 * i - 4 && n <= 16 * i + 4)
      end
      rd(6'h04, RESP_OKAY, 8'h15);
      wr(6'h38, 8'h00, RESP_OKAY);
      print_verdict();
   end
endmodule
`undef CHK
`default_nettype wire
